// file: rtl/hamd_decoder.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module hamd_decoder (
  input wire logic SYS_CLK, // 40 MHz clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic CLK_EN, // Freezes all state when low
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  input wire logic [3:0] REG_ADDR, // Register word index
  input wire logic [31:0] REG_WDATA, // Register write data
  output logic [31:0] REG_RDATA, // Register read data, cycle after strobe
  input wire logic REQ_VALID, // Access request strobe
  input wire logic [1:0] REQ_SRC, // Originating interface
  input wire logic [1:0] REQ_KIND, // Read, write or write-back
  input wire logic REQ_IO, // I/O cycle rather than memory
  input wire logic REQ_SMM, // Processor in management mode
  input wire logic [32:0] REQ_ADDR, // Access address, bit 32 above 4 GB
  output logic RSP_VALID, // Routing decision strobe
  output hamd_pkg::hamd_tgt_t RSP_TGT, // Selected destination
  output logic [31:0] RSP_ADDR, // Forwarded address, 32 bits only
  output logic RSP_ZERO_RD, // Read answered locally with zero data
  output logic RSP_ILLEGAL // Illegal VGA/mono enable combination
);
  // Register indices
  localparam logic [3:0] R_BRIDGE = 4'h0;
  localparam logic [3:0] R_SEG = 4'h1;
  localparam logic [3:0] R_TOM = 4'h2;
  localparam logic [3:0] R_SMM = 4'h3;
  localparam logic [3:0] R_NPWIN = 4'h4;
  localparam logic [3:0] R_PWIN = 4'h5;
  localparam logic [3:0] R_APER = 4'h6;
  localparam logic [3:0] R_STAT = 4'h7;

  logic vga_route_enable_q;
  logic mono_adapter_present_q;
  logic gfx_mem_en_q;
  logic fixed_hole_control_q;
  logic [25:0] seg_attr_q;
  logic [11:0] top_of_dram_q;
  logic [11:0] hole_base_q;
  logic smram_global_enable_q;
  logic smram_high_enable_q;
  logic top_segment_enable_q;
  logic [1:0] top_smram_segment_size_q;
  logic [11:0] nonpref_win_base_q;
  logic [11:0] nonpref_win_limit_q;
  logic [11:0] pref_win_base_q;
  logic [11:0] pref_win_limit_q;
  logic [9:0] aperture_base_addr_q;
  logic [2:0] aperture_size_sel_q;
  logic [15:0] route_cnt_q;
  logic [15:0] term_cnt_q;

  // Configuration registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vga_route_enable_q <= 1'b0;
      mono_adapter_present_q <= 1'b0;
      gfx_mem_en_q <= 1'b0;
      fixed_hole_control_q <= 1'b0;
      seg_attr_q <= hamd_pkg::SEG_RESET;
      top_of_dram_q <= 12'h000;
      hole_base_q <= 12'h000;
      smram_global_enable_q <= 1'b0;
      smram_high_enable_q <= 1'b0;
      top_segment_enable_q <= 1'b0;
      top_smram_segment_size_q <= 2'h0;
      nonpref_win_base_q <= 12'h000;
      nonpref_win_limit_q <= 12'h000;
      pref_win_base_q <= 12'h000;
      pref_win_limit_q <= 12'h000;
      aperture_base_addr_q <= 10'h000;
      aperture_size_sel_q <= hamd_pkg::AP_SZ_256M;
    end else if (CLK_EN && REG_WR) begin
      case (REG_ADDR)
        R_BRIDGE: begin
          vga_route_enable_q <= REG_WDATA[0];
          mono_adapter_present_q <= REG_WDATA[1];
          gfx_mem_en_q <= REG_WDATA[2];
          fixed_hole_control_q <= REG_WDATA[3];
          hole_base_q <= REG_WDATA[31:20];
        end
        R_SEG: seg_attr_q <= REG_WDATA[25:0];
        R_TOM: top_of_dram_q <= REG_WDATA[31:20];
        R_SMM: begin
          smram_global_enable_q <= REG_WDATA[0];
          smram_high_enable_q <= REG_WDATA[1];
          top_segment_enable_q <= REG_WDATA[2];
          top_smram_segment_size_q <= REG_WDATA[5:4];
        end
        R_NPWIN: begin
          nonpref_win_base_q <= REG_WDATA[15:4];
          nonpref_win_limit_q <= REG_WDATA[31:20];
        end
        R_PWIN: begin
          pref_win_base_q <= REG_WDATA[15:4];
          pref_win_limit_q <= REG_WDATA[31:20];
        end
        R_APER: begin
          aperture_base_addr_q <= REG_WDATA[31:22];
          aperture_size_sel_q <= REG_WDATA[2:0];
        end
        default: ;
      endcase
    end
  end

  // Aperture base with bits below the selected size forced to zero
  logic [4:0] ap_shift;
  logic [9:0] ap_mask;
  logic [9:0] ap_base_eff;
  always_comb begin
    ap_shift = (aperture_size_sel_q > 3'h6) ? 5'd6 : 5'(3'h6 - aperture_size_sel_q);
    ap_mask = 10'h3ff << ap_shift;
    ap_base_eff = aperture_base_addr_q & ap_mask;
  end

  // Decode of the current request
  logic [31:0] a;
  logic is_host;
  logic is_wr;
  logic smm_c_en;
  logic smm_h_en;
  logic smm_t_en;
  logic [31:0] tom_addr;
  logic [31:0] top_smram_segment_base;
  logic in_vid;
  logic in_mono;
  logic in_high_smram_segment;
  logic in_top_smram_segment;
  logic in_np;
  logic in_pf;
  logic in_ap;
  logic in_hole;
  logic mono_io;
  logic [3:0] seg_idx;
  logic seg_rd;
  logic seg_wr;
  logic [20:0] top_smram_segment_len;
  hamd_pkg::hamd_tgt_t vid_tgt;
  hamd_pkg::hamd_tgt_t tgt_d;
  logic [31:0] addr_d;

  always_comb begin
    a = REQ_ADDR[31:0];
    is_host = (REQ_SRC == hamd_pkg::SRC_HOST);
    is_wr = (REQ_KIND != hamd_pkg::KIND_READ);
    smm_c_en = smram_global_enable_q && !smram_high_enable_q;
    smm_h_en = smram_global_enable_q && smram_high_enable_q;
    smm_t_en = smram_global_enable_q && top_segment_enable_q;
    tom_addr = {top_of_dram_q, 20'h00000};
    // 21 bits so that the 1 MB setting does not wrap to zero
    top_smram_segment_len = 21'h020000 << top_smram_segment_size_q;
    top_smram_segment_base = tom_addr - {11'h000, top_smram_segment_len};
    in_vid = (a >= hamd_pkg::VID_BASE) && (a <= hamd_pkg::VID_TOP);
    in_mono = (a >= hamd_pkg::MONO_BASE) && (a <= hamd_pkg::MONO_TOP);
    in_high_smram_segment = (a >= hamd_pkg::HIGH_SMRAM_SEGMENT_BASE) && (a <= hamd_pkg::HIGH_SMRAM_SEGMENT_TOP);
    in_top_smram_segment = (a >= top_smram_segment_base) && (a < tom_addr);
    in_np = (a[31:20] >= nonpref_win_base_q) && (a[31:20] <= nonpref_win_limit_q);
    in_pf = (a[31:20] >= pref_win_base_q) && (a[31:20] <= pref_win_limit_q);
    in_ap = ((a[31:22] & ap_mask) == ap_base_eff);
    in_hole = fixed_hole_control_q && (a[31:20] == hole_base_q);
    mono_io = (a[9:0] == hamd_pkg::MONO_IO_0) || (a[9:0] == hamd_pkg::MONO_IO_1) ||
              (a[9:0] == hamd_pkg::MONO_IO_2) || (a[9:0] == hamd_pkg::MONO_IO_3) ||
              (a[9:0] == hamd_pkg::MONO_IO_4) || (a[9:0] == hamd_pkg::MONO_IO_5);
    seg_idx = 4'(a[19:14] - 6'h30);
    if (a >= hamd_pkg::SYSB_BASE) begin
      seg_idx = 4'(hamd_pkg::SYSB_SEG);
    end
    seg_rd = seg_attr_q[{seg_idx, 1'b0}];
    seg_wr = seg_attr_q[{seg_idx, 1'b1}];
    // Video path: graphics port only with VGA routing and memory enable
    vid_tgt = hamd_pkg::HAMD_TGT_HUB;
    if (vga_route_enable_q && gfx_mem_en_q) begin
      vid_tgt = hamd_pkg::HAMD_TGT_GFX;
    end
    if (in_mono && mono_adapter_present_q) begin
      vid_tgt = hamd_pkg::HAMD_TGT_HUB;
    end
    if (REQ_SRC == hamd_pkg::SRC_GFX && vid_tgt == hamd_pkg::HAMD_TGT_GFX) begin
      vid_tgt = hamd_pkg::HAMD_TGT_DROP;
    end
    if (REQ_SRC == hamd_pkg::SRC_HUB && vid_tgt == hamd_pkg::HAMD_TGT_GFX &&
        REQ_KIND != hamd_pkg::KIND_WRITE) begin
      vid_tgt = hamd_pkg::HAMD_TGT_DROP;
    end
    addr_d = a;
    // Priority chain, highest first
    if (REQ_ADDR[32]) begin
      tgt_d = hamd_pkg::HAMD_TGT_TERM;
      addr_d = 32'h00000000;
    end else if (REQ_IO) begin
      if (mono_adapter_present_q && vga_route_enable_q && mono_io) begin
        tgt_d = hamd_pkg::HAMD_TGT_HUB;
      end else if (vga_route_enable_q && gfx_mem_en_q && (a[9:2] != 8'hef) &&
                   (a[9:4] == 6'h3b || a[9:5] == 5'h1e)) begin
        tgt_d = hamd_pkg::HAMD_TGT_GFX;
      end else begin
        tgt_d = hamd_pkg::HAMD_TGT_HUB;
      end
    end else if (is_host && smm_h_en && in_high_smram_segment &&
                 (REQ_SMM || REQ_KIND == hamd_pkg::KIND_WRBACK)) begin
      tgt_d = hamd_pkg::HAMD_TGT_DRAM;
      addr_d = a ^ hamd_pkg::HIGH_SMRAM_SEGMENT_XOR;
    end else if (is_host && smm_t_en && in_top_smram_segment &&
                 (REQ_SMM || REQ_KIND == hamd_pkg::KIND_WRBACK)) begin
      tgt_d = hamd_pkg::HAMD_TGT_DRAM;
    end else if (is_host && ((smm_h_en && in_high_smram_segment) || (smm_t_en && in_top_smram_segment))) begin
      tgt_d = hamd_pkg::HAMD_TGT_TERM;
    end else if (is_host && REQ_SMM && smm_c_en && in_vid) begin
      tgt_d = hamd_pkg::HAMD_TGT_DRAM;
    end else if (a <= hamd_pkg::DOS_TOP) begin
      tgt_d = hamd_pkg::HAMD_TGT_DRAM;
    end else if (in_vid) begin
      tgt_d = vid_tgt;
    end else if (a < hamd_pkg::ONE_MB) begin
      tgt_d = (is_wr ? seg_wr : seg_rd) ? hamd_pkg::HAMD_TGT_DRAM
                                        : hamd_pkg::HAMD_TGT_HUB;
    end else if (a >= hamd_pkg::IOAPIC_BASE) begin
      tgt_d = hamd_pkg::HAMD_TGT_HUB;
    end else if (a < tom_addr) begin
      tgt_d = in_hole ? hamd_pkg::HAMD_TGT_HUB : hamd_pkg::HAMD_TGT_DRAM;
    end else if (gfx_mem_en_q && (in_np || in_pf) && REQ_SRC != hamd_pkg::SRC_GFX) begin
      tgt_d = hamd_pkg::HAMD_TGT_GFX;
    end else if (in_ap) begin
      tgt_d = hamd_pkg::HAMD_TGT_DRAM;
    end else begin
      tgt_d = hamd_pkg::HAMD_TGT_HUB;
    end
  end

  // Routing answer, one cycle after the request
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RSP_VALID <= 1'b0;
      RSP_TGT <= hamd_pkg::HAMD_TGT_HUB;
      RSP_ADDR <= 32'h00000000;
      RSP_ZERO_RD <= 1'b0;
    end else if (CLK_EN) begin
      RSP_VALID <= REQ_VALID;
      if (REQ_VALID) begin
        RSP_TGT <= tgt_d;
        RSP_ADDR <= addr_d;
        RSP_ZERO_RD <= REQ_ADDR[32] && !is_wr;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RSP_ILLEGAL <= 1'b0;
    end else if (CLK_EN) begin
      RSP_ILLEGAL <= mono_adapter_present_q && !vga_route_enable_q;
    end
  end

  // Activity counters
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      route_cnt_q <= 16'h0000;
      term_cnt_q <= 16'h0000;
    end else if (CLK_EN && REQ_VALID) begin
      route_cnt_q <= route_cnt_q + 16'h0001;
      if (tgt_d == hamd_pkg::HAMD_TGT_TERM) begin
        term_cnt_q <= term_cnt_q + 16'h0001;
      end
    end
  end

  // Register read port
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (CLK_EN) begin
      REG_RDATA <= 32'h00000000;
      if (REG_RD) begin
        case (REG_ADDR)
          R_BRIDGE: REG_RDATA <= {hole_base_q, 16'h0000, fixed_hole_control_q, gfx_mem_en_q,
                                  mono_adapter_present_q, vga_route_enable_q};
          R_SEG: REG_RDATA <= {6'h00, seg_attr_q};
          R_TOM: REG_RDATA <= {top_of_dram_q, 20'h00000};
          R_SMM: REG_RDATA <= {26'h0000000, top_smram_segment_size_q, 1'b0, top_segment_enable_q,
                               smram_high_enable_q, smram_global_enable_q};
          R_NPWIN: REG_RDATA <= {nonpref_win_limit_q, 4'h0, nonpref_win_base_q, 4'h0};
          R_PWIN: REG_RDATA <= {pref_win_limit_q, 4'h0, pref_win_base_q, 4'h0};
          R_APER: REG_RDATA <= {ap_base_eff, 19'h00000, aperture_size_sel_q};
          R_STAT: REG_RDATA <= {term_cnt_q, route_cnt_q};
          default: REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : hamd_decoder

// file: rtl/hamd_pkg.sv
package hamd_pkg;
  // Requesting source
  localparam logic [1:0] SRC_HOST = 2'h0;
  localparam logic [1:0] SRC_HUB = 2'h1;
  localparam logic [1:0] SRC_GFX = 2'h2;
  // Routing result
  typedef enum logic [2:0] {
    HAMD_TGT_DRAM,
    HAMD_TGT_HUB,
    HAMD_TGT_GFX,
    HAMD_TGT_TERM,
    HAMD_TGT_DROP
  } hamd_tgt_t;
  // Request transaction kinds
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_WRBACK = 2'h2;
  // Legacy ranges (address bits 31:0, 33-bit requests carry bit 32 separately)
  localparam logic [31:0] DOS_TOP = 32'h0009ffff;
  localparam logic [31:0] VID_BASE = 32'h000a0000;
  localparam logic [31:0] VID_TOP = 32'h000bffff;
  localparam logic [31:0] MONO_BASE = 32'h000b0000;
  localparam logic [31:0] MONO_TOP = 32'h000b7fff;
  localparam logic [31:0] EXP_BASE = 32'h000c0000;
  localparam logic [31:0] EXT_BASE = 32'h000e0000;
  localparam logic [31:0] SYSB_BASE = 32'h000f0000;
  localparam logic [31:0] ONE_MB = 32'h00100000;
  localparam int SEG_SHIFT = 14;
  localparam int NUM_SEG = 13;
  localparam int SYSB_SEG = 12;
  localparam logic [25:0] SEG_RESET = 26'h0000000;
  // High SMM segment and remap target
  localparam logic [31:0] HIGH_SMRAM_SEGMENT_BASE = 32'hfeea0000;
  localparam logic [31:0] HIGH_SMRAM_SEGMENT_TOP = 32'hfeebffff;
  localparam logic [31:0] HIGH_SMRAM_SEGMENT_XOR = 32'hfee00000;
  // APIC and high BIOS
  localparam logic [31:0] IOAPIC_BASE = 32'hfec00000;
  localparam logic [31:0] APIC_GAP_BASE = 32'hfed00000;
  localparam logic [31:0] HBIOS_BASE = 32'hffe00000;
  // Monochrome I/O ports
  localparam logic [9:0] MONO_IO_0 = 10'h3b4;
  localparam logic [9:0] MONO_IO_1 = 10'h3b5;
  localparam logic [9:0] MONO_IO_2 = 10'h3b8;
  localparam logic [9:0] MONO_IO_3 = 10'h3b9;
  localparam logic [9:0] MONO_IO_4 = 10'h3ba;
  localparam logic [9:0] MONO_IO_5 = 10'h3bf;
  // Aperture size selects: 6 minus the select (6 for select 7) is the number of low base bits forced to zero
  localparam logic [2:0] AP_SZ_256M = 3'h0;
  localparam int AP_MIN_SHIFT = 22;
  localparam int AP_MAX_SHIFT = 28;
endpackage : hamd_pkg

// file: dv/hamd_decoder_asserts.sv
`timescale 1ns/1ps
module hamd_decoder_checker (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_N, // Reset, active low
  input wire logic CLK_EN, // Run enable
  input wire logic REG_WR, // Register write
  input wire logic REQ_VALID, // Request
  input wire logic [1:0] REQ_SRC, // Source
  input wire logic [1:0] REQ_KIND, // Kind
  input wire logic REQ_IO, // I/O cycle
  input wire logic REQ_SMM, // Management mode
  input wire logic [32:0] REQ_ADDR, // Address
  input wire logic RSP_VALID, // Decision strobe
  input wire hamd_pkg::hamd_tgt_t RSP_TGT, // Destination
  input wire logic [31:0] RSP_ADDR, // Forwarded address
  input wire logic RSP_ZERO_RD // Zero read data
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  logic cfg_seen_q;
  wire logic mem = CLK_EN && REQ_VALID && !REQ_IO;
  wire logic low = mem && !REQ_ADDR[32];
  wire logic hst = low && (REQ_SRC == hamd_pkg::SRC_HOST);
  wire logic far = mem && REQ_ADDR[32];
  // Boot attributes are checked only until software first writes a register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_seen_q <= 1'b0;
    end else if (REG_WR) begin
      cfg_seen_q <= 1'b1;
    end
  end
  property p_answer;
    CLK_EN && REQ_VALID |=> RSP_VALID;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_idle;
    CLK_EN && !REQ_VALID |=> !RSP_VALID;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_hold;
    !(CLK_EN && REQ_VALID) |=> $stable(RSP_TGT);
  endproperty
  a_hold: assert property (p_hold) else $error("target moved without request");
  property p_far_term;
    far && REQ_SRC == hamd_pkg::SRC_HOST |=> RSP_TGT == hamd_pkg::HAMD_TGT_TERM
      && RSP_ADDR == 32'h0 && RSP_ZERO_RD == ($past(REQ_KIND) == hamd_pkg::KIND_READ);
  endproperty
  a_far_term: assert property (p_far_term) else $error("high access not ended");
  property p_no_dac;
    far |=> RSP_TGT != hamd_pkg::HAMD_TGT_HUB && RSP_TGT != hamd_pkg::HAMD_TGT_GFX;
  endproperty
  a_no_dac: assert property (p_no_dac) else $error("high address forwarded");
  property p_dos;
    low && REQ_ADDR[31:0] <= hamd_pkg::DOS_TOP |=> RSP_TGT == hamd_pkg::HAMD_TGT_DRAM
      && RSP_ADDR == $past(REQ_ADDR[31:0]);
  endproperty
  a_dos: assert property (p_dos) else $error("low area not in dram");
  property p_video;
    hst && !REQ_SMM && REQ_ADDR[31:17] == 15'h0005 |=>
      RSP_TGT == hamd_pkg::HAMD_TGT_HUB || RSP_TGT == hamd_pkg::HAMD_TGT_GFX;
  endproperty
  a_video: assert property (p_video) else $error("video access misrouted");
  property p_video_src;
    low && REQ_SRC != hamd_pkg::SRC_HOST && REQ_ADDR[31:17] == 15'h0005 |=>
      RSP_TGT != hamd_pkg::HAMD_TGT_DRAM;
  endproperty
  a_video_src: assert property (p_video_src) else $error("device reached smm");
  property p_boot_bios;
    hst && !cfg_seen_q && REQ_ADDR[31:16] == 16'h000f |=> RSP_TGT == hamd_pkg::HAMD_TGT_HUB;
  endproperty
  a_boot_bios: assert property (p_boot_bios) else $error("boot bios not on hub");
  property p_apic;
    low && REQ_ADDR[31:16] == 16'hfec0 |=> RSP_TGT == hamd_pkg::HAMD_TGT_HUB;
  endproperty
  a_apic: assert property (p_apic) else $error("apic not on hub");
  property p_hbios;
    low && REQ_ADDR[31:21] == 11'h7ff |=> RSP_TGT == hamd_pkg::HAMD_TGT_HUB;
  endproperty
  a_hbios: assert property (p_hbios) else $error("high bios not on hub");
endmodule : hamd_decoder_checker
bind hamd_decoder hamd_decoder_checker u_checker (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .CLK_EN(CLK_EN), .REG_WR(REG_WR), .REQ_VALID(REQ_VALID), .REQ_SRC(REQ_SRC),
  .REQ_KIND(REQ_KIND), .REQ_IO(REQ_IO), .REQ_SMM(REQ_SMM), .REQ_ADDR(REQ_ADDR),
  .RSP_VALID(RSP_VALID), .RSP_TGT(RSP_TGT), .RSP_ADDR(RSP_ADDR), .RSP_ZERO_RD(RSP_ZERO_RD));

// file: dv/hamd_sink_model.sv
`timescale 1ns/1ps
module hamd_sink_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic rsp_valid, // Decision strobe
  input wire hamd_pkg::hamd_tgt_t rsp_tgt // Destination
);
  // Tally of accesses claimed by each destination
  int unsigned hits_q [5];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hits_q <= '{default: 0};
    end else if (rsp_valid) begin
      hits_q[rsp_tgt] <= hits_q[rsp_tgt] + 1;
    end
  end
endmodule : hamd_sink_model

// file: dv/hamd_decoder_test.sv
`timescale 1ns/1ps
module hamd_decoder_test;
  localparam logic [1:0] SH = hamd_pkg::SRC_HOST, SU = hamd_pkg::SRC_HUB, SG = hamd_pkg::SRC_GFX;
  localparam logic [1:0] KR = 2'h0, KW = 2'h1, KB = 2'h2;
  localparam hamd_pkg::hamd_tgt_t DR = hamd_pkg::HAMD_TGT_DRAM, HB = hamd_pkg::HAMD_TGT_HUB;
  localparam hamd_pkg::hamd_tgt_t GX = hamd_pkg::HAMD_TGT_GFX, TM = hamd_pkg::HAMD_TGT_TERM;
  localparam hamd_pkg::hamd_tgt_t DP = hamd_pkg::HAMD_TGT_DROP;
  typedef struct {
    logic [1:0] src;
    logic [1:0] kind;
    logic smm;
    logic [32:0] addr;
    hamd_pkg::hamd_tgt_t tgt;
  } hamd_row_t;
  hamd_row_t rows [32] = '{'{SH, KR, 0, 33'h00009ffff, DR}, '{SH, KR, 0, 33'h0000a0000, GX},
    '{SH, KR, 1, 33'h0000a0000, DR}, '{SU, KW, 0, 33'h0000a0000, GX},
    '{SU, KR, 0, 33'h0000a0000, DP}, '{SG, KR, 1, 33'h0000bffff, DP},
    '{SH, KR, 0, 33'h0000b0000, HB}, '{SH, KR, 0, 33'h0000c0000, DR},
    '{SH, KW, 0, 33'h0000c3fff, HB}, '{SH, KR, 0, 33'h0000c4000, HB},
    '{SH, KW, 0, 33'h0000c4000, DR}, '{SH, KW, 0, 33'h0000dc000, HB},
    '{SH, KW, 0, 33'h0000e0000, DR}, '{SH, KR, 0, 33'h0000effff, HB},
    '{SH, KR, 0, 33'h000100000, DR}, '{SH, KR, 0, 33'h000f00000, HB},
    '{SH, KR, 0, 33'h003fdffff, DR}, '{SH, KR, 0, 33'h003fe0000, TM},
    '{SH, KR, 1, 33'h003fe0000, DR}, '{SH, KR, 0, 33'h004000000, HB},
    '{SH, KR, 0, 33'h080000000, GX}, '{SH, KR, 0, 33'h080ffffff, GX},
    '{SH, KR, 0, 33'h081000000, HB}, '{SU, KR, 0, 33'h080100000, GX},
    '{SH, KR, 0, 33'h0900fffff, GX}, '{SH, KR, 0, 33'h0cfffffff, DR},
    '{SH, KR, 0, 33'h0d0000000, HB}, '{SH, KR, 0, 33'h0fec0f000, HB},
    '{SH, KW, 0, 33'h0fed00000, HB}, '{SH, KR, 0, 33'h0ffe00000, HB},
    '{SH, KR, 0, 33'h100000000, TM}, '{SH, KW, 1, 33'h1ffffffff, TM}};
  logic [9:0] mono_io [6] = '{10'h3b4, 10'h3b5, 10'h3b8, 10'h3b9, 10'h3ba, 10'h3bf};
  logic SYS_CLK, RST_N, CLK_EN, REG_WR, REG_RD, REQ_VALID, REQ_IO, REQ_SMM;
  logic [3:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, RSP_ADDR;
  logic [1:0] REQ_SRC, REQ_KIND;
  logic [32:0] REQ_ADDR;
  logic RSP_VALID, RSP_ZERO_RD, RSP_ILLEGAL;
  hamd_pkg::hamd_tgt_t RSP_TGT;
  int mismatches, comparisons, cycles, n_term;
  hamd_decoder dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REQ_VALID(REQ_VALID), .REQ_SRC(REQ_SRC), .REQ_KIND(REQ_KIND), .REQ_IO(REQ_IO),
    .REQ_SMM(REQ_SMM), .REQ_ADDR(REQ_ADDR), .RSP_VALID(RSP_VALID), .RSP_TGT(RSP_TGT),
    .RSP_ADDR(RSP_ADDR), .RSP_ZERO_RD(RSP_ZERO_RD), .RSP_ILLEGAL(RSP_ILLEGAL));
  hamd_sink_model u_sink (.clk(SYS_CLK), .rst_n(RST_N), .rsp_valid(RSP_VALID), .rsp_tgt(RSP_TGT));
  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk32
  task automatic chk_tgt(input hamd_pkg::hamd_tgt_t g, input hamd_pkg::hamd_tgt_t e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_tgt
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1;
    chk32(REG_RDATA, e);
  endtask : rd
  task automatic req(input logic [1:0] s, input logic [1:0] k, input logic m, input logic io,
    input logic [32:0] a, input hamd_pkg::hamd_tgt_t t, input logic [31:0] ea);
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b1;
    REQ_SRC <= s;
    REQ_KIND <= k;
    REQ_SMM <= m;
    REQ_IO <= io;
    REQ_ADDR <= a;
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b0;
    #1;
    chk32({31'h0, RSP_VALID}, 32'h1);
    chk_tgt(RSP_TGT, t);
    chk32({31'h0, RSP_ZERO_RD}, {31'h0, a[32] && k == KR});
    if (!io && t != DP) chk32(RSP_ADDR, ea);
    if (t == TM) n_term++;
  endtask : req
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  // Run takes well under a thousand cycles
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {RST_N, REG_WR, REG_RD, REQ_VALID, REQ_IO, REQ_SMM, REQ_SRC, REQ_KIND} = '0;
    {REG_ADDR, REG_WDATA, REQ_ADDR} = '0;
    CLK_EN = 1'b1;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(4'h1, 32'h0);
    rd(4'hf, 32'h0);
    req(SH, KR, 0, 0, 33'h0000f0000, HB, 32'h000f0000);
    $display("test reset done");
    wr(4'h0, 32'h00f0000f);
    wr(4'h1, 32'h00030009);
    wr(4'h2, 32'h04000000);
    wr(4'h3, 32'h00000005);
    wr(4'h4, 32'h80f08000);
    wr(4'h5, 32'h90009000);
    wr(4'h6, 32'hc0400000);
    rd(4'h6, 32'hc0000000);
    foreach (rows[i]) req(rows[i].src, rows[i].kind, rows[i].smm, 0, rows[i].addr, rows[i].tgt,
      rows[i].addr[32] ? 32'h0 : rows[i].addr[31:0]);
    foreach (mono_io[i]) req(SH, KR, 0, 1, {23'h0, mono_io[i]}, HB, 32'h0);
    $display("test table done");
    wr(4'h3, 32'h00000007);
    req(SH, KR, 1, 0, 33'h0feea0010, DR, 32'h000a0010);
    req(SH, KR, 0, 0, 33'h0feea0010, TM, 32'hfeea0010);
    req(SH, KB, 0, 0, 33'h0feea0010, DR, 32'h000a0010);
    req(SH, KR, 1, 0, 33'h0000a0000, GX, 32'h000a0000);
    wr(4'h3, 32'h00000006);
    req(SH, KR, 0, 0, 33'h003fe0000, DR, 32'h03fe0000);
    $display("test smm done");
    wr(4'h0, 32'h00000004);
    req(SH, KR, 0, 0, 33'h0000a0000, HB, 32'h000a0000);
    wr(4'h0, 32'h00000002);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk32({31'h0, RSP_ILLEGAL}, 32'h1);
    wr(4'h0, 32'h00000005);
    req(SH, KR, 0, 0, 33'h0000b0000, GX, 32'h000b0000);
    req(SH, KR, 0, 1, 33'h0000003bf, HB, 32'h0);
    chk32({31'h0, RSP_ILLEGAL}, 32'h0);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    REQ_VALID <= 1'b1;
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b0;
    CLK_EN <= 1'b1;
    #1;
    chk32({31'h0, RSP_VALID}, 32'h0);
    chk32(32'(u_sink.hits_q[3]), 32'(n_term));
    $display("test vga and freeze done");
    wrap_up();
  end
endmodule : hamd_decoder_test
